// ### bench/pic_front_model.sv
`timescale 1ns/100ps
module pic_front_model (
    input wire logic clk,
    output logic sample_valid,
    output logic [143:0] pins
);
    initial begin
        sample_valid = 1'b0;
        pins = '0;
    end
    // Pins sit still before the strobe rises and well past the 3-clock hold
    task automatic send(input logic [143:0] p);
        @(posedge clk);
        pins <= p;
        @(posedge clk);
        sample_valid <= 1'b1;
        repeat (6) @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
        // Stale pins change so a late capture cannot pass by luck
        pins <= ~p;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ### bench/tb_pic_combiner.sv
`timescale 1ns/100ps
module tb_pic_combiner;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [23:0] wdata = 24'h000000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sample_valid;
    logic [143:0] pins;
    logic [23:0] rdata, va, vb, vc, ia, ib, ic;
    logic rv, g_a, g_b, g_c;
    logic [4:0] alarm;
    int failures = 0;
    int n_compared = 0;
    int n_rv = 0;

    always #50 clk = ~clk;
    always @(posedge clk) if (rv === 1'b1) n_rv++;

    pic_front_model pic_front_model_inst (.clk(clk),
        .sample_valid(sample_valid), .pins(pins));
    pic_combiner pic_combiner_inst (.clk(clk), .rst_n(rst_n),
        .sample_valid(sample_valid), .voltage_pin_1(pins[23:0]),
        .voltage_pin_2(pins[47:24]), .voltage_pin_3(pins[71:48]),
        .current_pin_1(pins[95:72]), .current_pin_2(pins[119:96]),
        .current_pin_3(pins[143:120]), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .phase_va(va),
        .phase_vb(vb), .phase_vc(vc), .phase_ia(ia), .phase_ib(ib),
        .phase_ic(ic), .result_valid(rv), .gain8_enable_a(g_a),
        .gain8_enable_b(g_b), .gain8_enable_c(g_c), .alarm_pins(alarm));

    task automatic check(input string n, input logic [23:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rchk(input string n, input logic [3:0] a,
                        input logic [23:0] e);
        logic [23:0] d;
        rd(a, d);
        check(n, d, e);
    endtask

    function automatic logic [143:0] model(input logic [23:0] s,
                                           input logic [143:0] p);
        logic [23:0] v[3], c[3], t[3];
        int k;
        for (k = 0; k < 3; k++) begin
            v[k] = s[20+k] ? -p[24*k +: 24] : p[24*k +: 24];
            c[k] = p[72+24*k +: 24];
            t[k] = v[k];
        end
        if (s[5]) begin
            t[0] = v[2] - v[0];
            t[1] = v[0] - v[1];
            t[2] = v[1] - v[2];
        end else if (s[4:3] == 2'h1) t[0] = v[2] - v[1];
        else if (s[4:3] == 2'h2) t[1] = v[0] - v[2];
        else if (s[4:3] == 2'h3) t[2] = v[1] - v[0];
        k = int'(s[1:0]) - 1;
        if (k >= 0) begin
            if (s[2]) c[k] = c[k] - (c[(k+1)%3] + c[(k+2)%3]);
            else if (s[5]) c[k] = c[(k+1)%3] - c[(k+2)%3];
            else c[k] = -(c[(k+1)%3] + c[(k+2)%3]);
        end
        return {c[2], c[1], c[0], t[2], t[1], t[0]};
    endfunction

    task automatic sample(input logic [23:0] s, input logic [143:0] p);
        logic [143:0] e;
        int n0;
        e = model(s, p);
        n0 = n_rv;
        wr(pic_pkg::ADDR_SETUP, s);
        pic_front_model_inst.send(p);
        check("result pulses", 24'(n_rv), 24'(n0 + 1));
        check("va", va, e[23:0]);
        check("vb", vb, e[47:24]);
        check("vc", vc, e[71:48]);
        check("ia", ia, e[95:72]);
        check("ib", ib, e[119:96]);
        check("ic", ic, e[143:120]);
    endtask

    task automatic t_reset;
        rchk("setup", pic_pkg::ADDR_SETUP, 24'h000000);
        rchk("length", pic_pkg::ADDR_INTERVAL_LEN, 24'h00021C);
        rchk("control", pic_pkg::ADDR_CONTROL, 24'h000000);
        wr(4'h7, 24'hFFFFFF);
        rchk("unmapped", 4'h7, 24'h000000);
        wr(pic_pkg::ADDR_TICKS, 24'h000005);
        rchk("ticks ro", pic_pkg::ADDR_TICKS, 24'h000000);
    endtask

    task automatic t_modes;
        // Neutral flag never goes with absent current code 00
        logic [23:0] cfg[12] = '{24'h000000, 24'h700008, 24'h100010,
            24'h200018, 24'h400020, 24'h000001, 24'h000002, 24'h000003,
            24'h000021, 24'h000022, 24'h000005, 24'h000007};
        for (int j = 0; j < 12; j++) begin
            sample(cfg[j], {24'd5, 24'd20, 24'd50, 24'd7, 24'd30, 24'd100});
            rchk("setup", pic_pkg::ADDR_SETUP, cfg[j]);
        end
    endtask

    task automatic t_gain;
        wr(pic_pkg::ADDR_SETUP, 24'h002200);
        repeat (3) @(posedge clk);
        check("gain held", {21'h0, g_a, g_b, g_c}, 24'h000000);
        sample(24'h002200, 144'h0);
        check("gain", {21'h0, g_a, g_b, g_c}, 24'h000005);
    endtask

    task automatic t_interval;
        logic [23:0] n0, d;
        wr(pic_pkg::ADDR_INTERVAL_LEN, 24'h000004);
        wr(pic_pkg::ADDR_CONTROL, 24'h00000E);
        sample(24'h000000, 144'h0);
        wr(pic_pkg::ADDR_STATUS, 24'h000001);
        rd(pic_pkg::ADDR_INTERVALS, n0);
        for (int j = 1; j <= 3; j++) sample(24'h0, {120'h0, 24'(8 * j)});
        rchk("ticks", pic_pkg::ADDR_TICKS, 24'h000003);
        check("alarm idle", {19'h0, alarm}, 24'h000000);
        sample(24'h0, {120'h0, 24'd32});
        rchk("ticks", pic_pkg::ADDR_TICKS, 24'h000000);
        rchk("last length", pic_pkg::ADDR_LAST_LEN, 24'h000004);
        rchk("intervals", pic_pkg::ADDR_INTERVALS, n0 + 24'h1);
        rchk("average va", pic_pkg::ADDR_AVG_VA, 24'd20);
        rd(pic_pkg::ADDR_STATUS, d);
        check("ready", {23'h0, d[0]}, 24'h000001);
        check("alarm", {19'h0, alarm}, 24'h000008);
        wr(pic_pkg::ADDR_STATUS, 24'h000001);
        rd(pic_pkg::ADDR_STATUS, d);
        check("ready clear", {23'h0, d[0]}, 24'h000000);
    endtask

    task automatic t_lock;
        logic [23:0] n0;
        wr(pic_pkg::ADDR_CONTROL, 24'h000001);
        rd(pic_pkg::ADDR_INTERVALS, n0);
        repeat (103) sample(24'h0, 144'h0);
        rchk("lock hold", pic_pkg::ADDR_INTERVALS, n0);
        sample(24'h0, 144'h0);
        rchk("lock end", pic_pkg::ADDR_INTERVALS, n0 + 24'h1);
        rchk("lock length", pic_pkg::ADDR_LAST_LEN, 24'd104);
    endtask

    task automatic summarize;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_gain();
        t_interval();
        t_lock();
        summarize();
    end
endmodule

// ### logic/pic_combiner.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Overview of operation
// - Negate a voltage input first when its negate bit is set.
// - Direct mode: phases A, B, C come from voltage pins 1, 2, 3.
// - One absent voltage sensor: rebuild it from the other two (A=C-B, B=A-C, C=B-A).
// - Line-to-line mode: A=C-A, B=A-B, C=B-C; absent codes invalid.
// - Absent voltage sensor code lives at setup bits 4:3.
// - Absent current code at bits 1:0, neutral sensor flag at bit 2.
// - No neutral, wye: absent current is minus sum of the other two.
// - No neutral, line-to-line: absent current is difference of others.
// - Neutral used: absent current is neutral minus sum of others.
// - Gain-eight enables for A, B, C at setup bits 13, 11, 9.
// - Instantaneous phase results update every high-rate sample.
// - 24-bit sample tick counter; clears when interval results update.
// - Interval counter increments at end of every interval.
// - Data-ready flag in status, optionally on one of five alarm pins.
// - Low-rate result is the average of the interval's samples.
// - Without lock, interval ends after the programmed sample count.
// - With lock and AC, extend to next positive composite crossing.
// - With lock and no AC, end at most 100 samples past count.
// - Store actual sample count of each finished interval.
// - Composite crossing signal is A - B/2 - C/4.
module pic_combiner #(
    parameter int W = pic_pkg::SAMPLE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [W-1:0] voltage_pin_1,
    input wire logic [W-1:0] voltage_pin_2,
    input wire logic [W-1:0] voltage_pin_3,
    input wire logic [W-1:0] current_pin_1,
    input wire logic [W-1:0] current_pin_2,
    input wire logic [W-1:0] current_pin_3,
    input wire logic [3:0] addr,
    input wire logic [23:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [23:0] rdata,
    output logic [W-1:0] phase_va,
    output logic [W-1:0] phase_vb,
    output logic [W-1:0] phase_vc,
    output logic [W-1:0] phase_ia,
    output logic [W-1:0] phase_ib,
    output logic [W-1:0] phase_ic,
    output logic result_valid,
    output logic gain8_enable_a,
    output logic gain8_enable_b,
    output logic gain8_enable_c,
    output logic [4:0] alarm_pins
);
    localparam int AW = W + 24;

    typedef struct packed {
        logic [23:0] setup;
        logic [23:0] active;
        logic [23:0] interval_len;
        logic [23:0] control;
        logic [23:0] ticks;
        logic [23:0] last_len;
        logic [23:0] intervals;
        logic ready;
        logic [W-1:0] va;
        logic [W-1:0] vb;
        logic [W-1:0] vc;
        logic [W-1:0] ia;
        logic [W-1:0] ib;
        logic [W-1:0] ic;
        logic res_valid;
        logic [AW-1:0] acc_va;
        logic [AW-1:0] acc_ia;
        logic [W-1:0] avg_va;
        logic [W-1:0] avg_ia;
        logic zc_neg;
        logic [3:0] zc_seen;
        logic ac_ok;
        logic [23:0] rdata;
        logic [4:0] alarm;
        logic [W-1:0] pin_v1_s1, pin_v2_s1, pin_v3_s1;
        logic [W-1:0] pin_i1_s1, pin_i2_s1, pin_i3_s1;
        logic vld_s1, vld_s2, vld_s3;
    } pic_state_type;

    pic_state_type st_r;
    pic_state_type st_nxt;

    // Second synchroniser stage for the pins; first stage lives in st_r
    logic [W-1:0] v1_s2, v2_s2, v3_s2, i1_s2, i2_s2, i3_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            v1_s2 <= '0;
            v2_s2 <= '0;
            v3_s2 <= '0;
            i1_s2 <= '0;
            i2_s2 <= '0;
            i3_s2 <= '0;
        end else begin
            v1_s2 <= st_r.pin_v1_s1;
            v2_s2 <= st_r.pin_v2_s1;
            v3_s2 <= st_r.pin_v3_s1;
            i1_s2 <= st_r.pin_i1_s1;
            i2_s2 <= st_r.pin_i2_s1;
            i3_s2 <= st_r.pin_i3_s1;
        end
    end

    logic [W-1:0] n1, n2, n3, va_c, vb_c, vc_c, ia_c, ib_c, ic_c, zc;
    logic [1:0] abs_v, abs_i;
    logic ltl, neu, tick, at_end, over_cnt;
    logic [23:0] cnt_next;
    logic [23:0] cfg;

    always_comb begin
        st_nxt = st_r;
        tick = st_r.vld_s2 && !st_r.vld_s3;
        // A tick computes with the setup it adopts, so a write made
        // before the sample governs all of it and never only a part
        cfg = tick ? st_r.setup : st_r.active;
        abs_v = cfg[pic_pkg::ABS_V_LO +: 2];
        abs_i = cfg[pic_pkg::ABS_I_LO +: 2];
        neu = cfg[pic_pkg::NEUTRAL_BIT];
        ltl = cfg[pic_pkg::LTL_BIT];

        // Negation ahead of all combining
        n1 = cfg[pic_pkg::NEG_V1_BIT] ? -v1_s2 : v1_s2;
        n2 = cfg[pic_pkg::NEG_V2_BIT] ? -v2_s2 : v2_s2;
        n3 = cfg[pic_pkg::NEG_V3_BIT] ? -v3_s2 : v3_s2;
        va_c = n1;
        vb_c = n2;
        vc_c = n3;
        if (ltl) begin
            // Invalid absent codes are ignored here: pins used as measured
            va_c = n3 - n1;
            vb_c = n1 - n2;
            vc_c = n2 - n3;
        end else begin
            unique case (abs_v)
                2'h0: ;
                2'h1: va_c = n3 - n2;
                2'h2: vb_c = n1 - n3;
                2'h3: vc_c = n2 - n1;
            endcase
        end

        ia_c = i1_s2;
        ib_c = i2_s2;
        ic_c = i3_s2;
        // Neutral with code 00 is a host error; treated as three sensors
        unique case (abs_i)
            2'h0: ;
            2'h1: ia_c = neu ? i1_s2 - (i2_s2 + i3_s2)
                       : ltl ? i2_s2 - i3_s2 : -(i2_s2 + i3_s2);
            2'h2: ib_c = neu ? i2_s2 - (i3_s2 + i1_s2)
                       : ltl ? i3_s2 - i1_s2 : -(i3_s2 + i1_s2);
            2'h3: ic_c = neu ? i3_s2 - (i1_s2 + i2_s2)
                       : ltl ? i1_s2 - i2_s2 : -(i1_s2 + i2_s2);
        endcase

        zc = va_c - {vb_c[W-1], vb_c[W-1:1]}
             - {{2{vc_c[W-1]}}, vc_c[W-1:2]};

        cnt_next = st_r.ticks + 24'h000001;
        over_cnt = cnt_next >= st_r.interval_len;
        at_end = 1'b0;
        if (!st_r.control[pic_pkg::CTL_LOCK_BIT]) begin
            at_end = over_cnt;
        end else if (cnt_next >= st_r.interval_len + pic_pkg::LOCK_TIMEOUT)
        begin
            at_end = 1'b1;
        end else if (over_cnt && st_r.ac_ok) begin
            at_end = st_r.zc_neg && !zc[W-1];
        end

        st_nxt.res_valid = 1'b0;
        if (tick) begin
            st_nxt.active = st_r.setup;
            st_nxt.va = va_c;
            st_nxt.vb = vb_c;
            st_nxt.vc = vc_c;
            st_nxt.ia = ia_c;
            st_nxt.ib = ib_c;
            st_nxt.ic = ic_c;
            st_nxt.res_valid = 1'b1;
            st_nxt.zc_neg = zc[W-1];
            if (st_r.zc_neg && !zc[W-1] && st_r.zc_seen != 4'hF) begin
                st_nxt.zc_seen = st_r.zc_seen + 4'h1;
            end
            if (at_end) begin
                st_nxt.ticks = '0;
                st_nxt.intervals = st_r.intervals + 24'h000001;
                st_nxt.last_len = cnt_next;
                st_nxt.ready = 1'b1;
                // Averages divide by the count; a divider is costly but rare
                // Signed divide: samples are two's complement values
                st_nxt.avg_va = W'($signed(st_r.acc_va + AW'(signed'(va_c)))
                    / $signed(AW'(cnt_next)));
                st_nxt.avg_ia = W'($signed(st_r.acc_ia + AW'(signed'(ia_c)))
                    / $signed(AW'(cnt_next)));
                st_nxt.acc_va = '0;
                st_nxt.acc_ia = '0;
                st_nxt.ac_ok = st_r.zc_seen >= pic_pkg::AC_VALID_CROSSINGS;
                st_nxt.zc_seen = '0;
            end else begin
                st_nxt.ticks = cnt_next;
                st_nxt.acc_va = st_r.acc_va + AW'(signed'(va_c));
                st_nxt.acc_ia = st_r.acc_ia + AW'(signed'(ia_c));
            end
        end

        st_nxt.rdata = '0;
        if (wr_en) begin
            unique case (addr)
                pic_pkg::ADDR_SETUP: st_nxt.setup = wdata;
                pic_pkg::ADDR_INTERVAL_LEN: st_nxt.interval_len = wdata;
                pic_pkg::ADDR_CONTROL: st_nxt.control = wdata;
                // Write one clears ready; a same-cycle interval end wins
                pic_pkg::ADDR_STATUS:
                    if (wdata[pic_pkg::STS_READY_BIT] && !(tick && at_end))
                        st_nxt.ready = 1'b0;
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                pic_pkg::ADDR_SETUP: st_nxt.rdata = st_r.setup;
                pic_pkg::ADDR_TICKS: st_nxt.rdata = st_r.ticks;
                pic_pkg::ADDR_INTERVAL_LEN: st_nxt.rdata = st_r.interval_len;
                pic_pkg::ADDR_LAST_LEN: st_nxt.rdata = st_r.last_len;
                pic_pkg::ADDR_INTERVALS: st_nxt.rdata = st_r.intervals;
                pic_pkg::ADDR_STATUS:
                    st_nxt.rdata = {22'h000000, st_r.ac_ok, st_r.ready};
                pic_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control;
                pic_pkg::ADDR_VA: st_nxt.rdata = 24'(st_r.va);
                pic_pkg::ADDR_VB: st_nxt.rdata = 24'(st_r.vb);
                pic_pkg::ADDR_VC: st_nxt.rdata = 24'(st_r.vc);
                pic_pkg::ADDR_IA: st_nxt.rdata = 24'(st_r.ia);
                pic_pkg::ADDR_IB: st_nxt.rdata = 24'(st_r.ib);
                pic_pkg::ADDR_IC: st_nxt.rdata = 24'(st_r.ic);
                pic_pkg::ADDR_AVG_VA: st_nxt.rdata = 24'(st_r.avg_va);
                pic_pkg::ADDR_AVG_IA: st_nxt.rdata = 24'(st_r.avg_ia);
                default: st_nxt.rdata = '0;
            endcase
        end

        st_nxt.alarm = '0;
        for (int k = 0; k < pic_pkg::ALARM_PINS; k++) begin
            st_nxt.alarm[k] = st_nxt.ready
                && st_r.control[pic_pkg::CTL_ALARM_EN_BIT]
                && (st_r.control[pic_pkg::CTL_ALARM_SEL_LO +: 3] == 3'(k));
        end

        st_nxt.pin_v1_s1 = voltage_pin_1;
        st_nxt.pin_v2_s1 = voltage_pin_2;
        st_nxt.pin_v3_s1 = voltage_pin_3;
        st_nxt.pin_i1_s1 = current_pin_1;
        st_nxt.pin_i2_s1 = current_pin_2;
        st_nxt.pin_i3_s1 = current_pin_3;
        st_nxt.vld_s1 = sample_valid;
        st_nxt.vld_s2 = st_r.vld_s1;
        // Third stage holds the previous strobe so tick marks its rising edge
        st_nxt.vld_s3 = st_r.vld_s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.setup <= pic_pkg::SETUP_RST;
            st_r.active <= pic_pkg::SETUP_RST;
            st_r.interval_len <= pic_pkg::INTERVAL_LEN_RST;
            st_r.control <= pic_pkg::CONTROL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign phase_va = st_r.va;
    assign phase_vb = st_r.vb;
    assign phase_vc = st_r.vc;
    assign phase_ia = st_r.ia;
    assign phase_ib = st_r.ib;
    assign phase_ic = st_r.ic;
    assign result_valid = st_r.res_valid;
    assign gain8_enable_a = st_r.active[pic_pkg::GAIN_A_BIT];
    assign gain8_enable_b = st_r.active[pic_pkg::GAIN_B_BIT];
    assign gain8_enable_c = st_r.active[pic_pkg::GAIN_C_BIT];
    assign alarm_pins = st_r.alarm;

    a_ticks_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && at_end) |=> (st_r.ticks == 24'h000000))
        else $error("tick counter not cleared at interval end");
    a_interval_count: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && at_end) |=> (st_r.intervals == $past(st_r.intervals)
            + 24'h000001))
        else $error("interval counter did not step");
    a_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && at_end) |=> st_r.ready)
        else $error("ready flag not set at interval end");
    a_fixed_end: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !st_r.control[0] && cnt_next == st_r.interval_len)
            |-> at_end)
        else $error("fixed interval did not end on count");
    a_lock_timeout: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.ticks <= st_r.interval_len + pic_pkg::LOCK_TIMEOUT))
        else $error("lock interval passed timeout");
    a_last_len: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && at_end) |=> (st_r.last_len == $past(cnt_next)))
        else $error("last interval length wrong");
    a_direct_map: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5:3] == 3'h0 && st_r.setup[22:20] == 3'h0)
            |=> (phase_va == $past(v1_s2) && phase_vc == $past(v3_s2)))
        else $error("direct voltage mapping wrong");
    a_ltl_sum: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5]) |=> (W'(phase_va + phase_vb + phase_vc)
            == '0))
        else $error("line-to-line values do not sum to zero");
    a_neg_first: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5:3] == 3'h0 && st_r.setup[20])
            |=> (phase_va == W'(-$past(v1_s2))))
        else $error("voltage one not negated");
    a_wye_current: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5] == 1'b0 && st_r.setup[2:0] == 3'h1)
            |=> (W'(phase_ia + phase_ib + phase_ic) == '0))
        else $error("rebuilt current does not close the sum");

    // Per-mode equations checked against the synchronised pin values
    a_absent_va: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5:3] == 3'h1 && st_r.setup[22:20] == 3'h0)
            |=> (phase_va == W'($past(v3_s2) - $past(v2_s2))))
        else $error("absent voltage one not rebuilt");
    a_absent_vb: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5:3] == 3'h2 && st_r.setup[22:20] == 3'h0)
            |=> (phase_vb == W'($past(v1_s2) - $past(v3_s2))))
        else $error("absent voltage two not rebuilt");
    a_absent_vc: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5:3] == 3'h3 && st_r.setup[22:20] == 3'h0)
            |=> (phase_vc == W'($past(v2_s2) - $past(v1_s2))))
        else $error("absent voltage three not rebuilt");
    a_ltl_va: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5] && st_r.setup[22:20] == 3'h0)
            |=> (phase_va == W'($past(v3_s2) - $past(v1_s2))))
        else $error("line-to-line phase A wrong");
    a_delta_current: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[5] && st_r.setup[2:0] == 3'h1)
            |=> (phase_ia == W'($past(i2_s2) - $past(i3_s2))))
        else $error("line-to-line absent current wrong");
    a_neutral_current: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && st_r.setup[2:0] == 3'h5) |=> (phase_ia
            == W'($past(i1_s2) - $past(i2_s2) - $past(i3_s2))))
        else $error("neutral based current wrong");
    a_gain_map: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> (gain8_enable_a == $past(st_r.setup[13])
            && gain8_enable_c == $past(st_r.setup[9])))
        else $error("gain enable not taken from setup");
    a_setup_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> $stable(st_r.active))
        else $error("setup applied between samples");
    a_result_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> result_valid)
        else $error("no result pulse after sample");
    a_result_single: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> !result_valid)
        else $error("result pulse without sample");
    a_ticks_step: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !at_end) |=> (st_r.ticks == $past(st_r.ticks)
            + 24'h000001))
        else $error("tick counter did not step");
endmodule

// ### logic/pic_pkg.sv
package pic_pkg;
    localparam int SAMPLE_W = 24;
    // Register addresses on the plain port (word index)
    localparam logic [3:0] ADDR_SETUP = 4'h0;
    localparam logic [3:0] ADDR_TICKS = 4'h1;
    localparam logic [3:0] ADDR_INTERVAL_LEN = 4'h2;
    localparam logic [3:0] ADDR_LAST_LEN = 4'h3;
    localparam logic [3:0] ADDR_INTERVALS = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_CONTROL = 4'h6;
    localparam logic [3:0] ADDR_VA = 4'h8;
    localparam logic [3:0] ADDR_VB = 4'h9;
    localparam logic [3:0] ADDR_VC = 4'hA;
    localparam logic [3:0] ADDR_IA = 4'hB;
    localparam logic [3:0] ADDR_IB = 4'hC;
    localparam logic [3:0] ADDR_IC = 4'hD;
    localparam logic [3:0] ADDR_AVG_VA = 4'hE;
    localparam logic [3:0] ADDR_AVG_IA = 4'hF;
    // Setup field positions
    localparam int ABS_I_LO = 0;
    localparam int NEUTRAL_BIT = 2;
    localparam int ABS_V_LO = 3;
    localparam int LTL_BIT = 5;
    localparam int GAIN_C_BIT = 9;
    localparam int GAIN_B_BIT = 11;
    localparam int GAIN_A_BIT = 13;
    localparam int NEG_V1_BIT = 20;
    localparam int NEG_V2_BIT = 21;
    localparam int NEG_V3_BIT = 22;
    // Control register fields
    localparam int CTL_LOCK_BIT = 0;
    localparam int CTL_ALARM_EN_BIT = 1;
    localparam int CTL_ALARM_SEL_LO = 2;
    // Status register fields
    localparam int STS_READY_BIT = 0;
    localparam int STS_AC_BIT = 1;
    // Reset values and fixed limits
    localparam logic [23:0] SETUP_RST = 24'h000000;
    localparam logic [23:0] INTERVAL_LEN_RST = 24'h00021C;
    localparam logic [23:0] LOCK_TIMEOUT = 24'h000064;
    localparam logic [23:0] CONTROL_RST = 24'h000000;
    localparam int ALARM_PINS = 5;
    localparam logic [3:0] AC_VALID_CROSSINGS = 4'h2;
endpackage
